// ==== hdl/flash_bus_cycle.sv ====
// one write or read cycle on the flash pins, with the data input synchroniser
`timescale 1ns/1ps
module flash_bus_cycle
  import flash_seq_pkg::*;
(
  // clock, reset, enable
  input  wire logic              clock_i,
  input  wire logic              rst_sync_i,
  input  wire logic              clock_en_i,
  // sequencer side
  flash_bus_if.engine            bus,
  // flash pins
  output logic                   flash_ce_n_o,
  output logic                   flash_oe_n_o,
  output logic                   flash_we_n_o,
  output logic [ADDR_W-1:0]      flash_addr_o,
  output logic [DATA_W-1:0]      flash_dq_o,
  output logic                   flash_dq_oe_o,
  input  wire logic [DATA_W-1:0] flash_dq_i
);

  typedef enum logic [2:0] {CYC_IDLE, CYC_SETUP, CYC_STROBE, CYC_HOLD, CYC_SETTLE} cyc_type;

  cyc_type           state, next_state;
  logic [CNT_W-1:0]  cnt, next_cnt;
  logic              ce_n, next_ce_n, oe_n, next_oe_n, we_n, next_we_n;
  logic [ADDR_W-1:0] addr, next_addr;
  logic [DATA_W-1:0] dq_out, next_dq_out, rdata, next_rdata;
  logic              dq_oe, next_dq_oe, done, next_done;
  logic [DATA_W-1:0] sync1, sync2, sync3;

  always_comb
  begin
    next_state  = state;
    next_cnt    = cnt;
    next_ce_n   = ce_n;
    next_oe_n   = oe_n;
    next_we_n   = we_n;
    next_addr   = addr;
    next_dq_out = dq_out;
    next_dq_oe  = dq_oe;
    next_rdata  = rdata;
    next_done   = 1'b0;
    case (state)
      CYC_IDLE:
        if (bus.req)
        begin
          next_addr = bus.addr;
          next_ce_n = 1'b0;
          if (bus.write)
          begin
            next_dq_out = bus.wdata;
            next_dq_oe  = 1'b1;
            next_state  = CYC_SETUP;
          end
          else
          begin
            next_oe_n  = 1'b0;
            next_cnt   = READ_LOAD;
            next_state = CYC_STROBE;
          end
        end
      CYC_SETUP:
      begin
        // address settles a cycle before the write strobe falls
        next_we_n  = 1'b0;
        next_cnt   = WE_LOW_LOAD;
        next_state = CYC_STROBE;
      end
      CYC_STROBE:
        if (cnt != CNT_ZERO)
          next_cnt = cnt - 4'h1;
        else if (!we_n)
        begin
          next_we_n  = 1'b1;
          next_state = CYC_HOLD;
        end
        else
          next_state = CYC_SETTLE;
      CYC_HOLD:
      begin
        // data held one cycle past the rising strobe
        next_ce_n  = 1'b1;
        next_dq_oe = 1'b0;
        next_done  = 1'b1;
        next_state = CYC_IDLE;
      end
      CYC_SETTLE:
        if (sync2 == sync3)
        begin
          next_rdata = sync3;
          next_ce_n  = 1'b1;
          next_oe_n  = 1'b1;
          next_done  = 1'b1;
          next_state = CYC_IDLE;
        end
      default:
        next_state = CYC_IDLE;
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_sync_i)
  begin
    if (!rst_sync_i)
    begin
      state  <= CYC_IDLE;
      cnt    <= CNT_ZERO;
      ce_n   <= 1'b1;
      oe_n   <= 1'b1;
      we_n   <= 1'b1;
      addr   <= '0;
      dq_out <= '0;
      dq_oe  <= 1'b0;
      rdata  <= '0;
      done   <= 1'b0;
      sync1  <= '0;
      sync2  <= '0;
      sync3  <= '0;
    end
    else if (clock_en_i)
    begin
      state  <= next_state;
      cnt    <= next_cnt;
      ce_n   <= next_ce_n;
      oe_n   <= next_oe_n;
      we_n   <= next_we_n;
      addr   <= next_addr;
      dq_out <= next_dq_out;
      dq_oe  <= next_dq_oe;
      rdata  <= next_rdata;
      done   <= next_done;
      sync1  <= flash_dq_i;
      sync2  <= sync1;
      sync3  <= sync2;
    end
  end

  assign bus.done      = done;
  assign bus.rdata     = rdata;
  assign flash_ce_n_o  = ce_n;
  assign flash_oe_n_o  = oe_n;
  assign flash_we_n_o  = we_n;
  assign flash_addr_o  = addr;
  assign flash_dq_o    = dq_out;
  assign flash_dq_oe_o = dq_oe;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_sync_i);

  property p_we_inside_ce;
    !we_n |-> !ce_n && oe_n;
  endproperty
  a_we_inside_ce: assert property (p_we_inside_ce) else $error("write strobe outside select");

  property p_no_drive_on_read;
    !oe_n |-> !dq_oe;
  endproperty
  a_no_drive_on_read: assert property (p_no_drive_on_read) else $error("bus fight on read");

  property p_data_stable_strobe;
    !we_n && $past(!we_n) |-> $stable(dq_out) && $stable(addr) && dq_oe;
  endproperty
  a_data_stable_strobe: assert property (p_data_stable_strobe) else $error("write data moved");

endmodule : flash_bus_cycle

// ==== hdl/flash_bus_if.sv ====
// single flash bus cycle request and answer between sequencer and engine
`timescale 1ns/1ps
interface flash_bus_if;
  import flash_seq_pkg::*;
  logic              req;
  logic              write;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              done;
  logic [DATA_W-1:0] rdata;

  modport master (output req, output write, output addr, output wdata,
                  input done, input rdata);
  modport engine (input req, input write, input addr, input wdata,
                  output done, output rdata);
endinterface : flash_bus_if

// ==== hdl/flash_host_sequencer.sv ====
// host controller that drives unlock, program, erase and status polling on a parallel NOR flash
`timescale 1ns/1ps
module flash_host_sequencer
  import flash_seq_pkg::*;
#(
  parameter int ERASE_LIMIT_CYCLES = 12_500_000
)
(
  // clock, reset, enable
  input  wire logic              clock_i,
  input  wire logic              rst_n_i,
  input  wire logic              clock_en_i,
  // command port
  input  wire logic              cmd_valid_i,
  input  wire op_type            cmd_op_i,
  input  wire logic [ADDR_W-1:0] cmd_addr_i,
  input  wire logic [DATA_W-1:0] cmd_data_i,
  output logic                   cmd_ready_o,
  // answer port
  output logic                   rsp_valid_o,
  output logic [DATA_W-1:0]      rsp_data_o,
  output logic                   rsp_error_o,
  // flash pins
  output logic                   flash_ce_n_o,
  output logic                   flash_oe_n_o,
  output logic                   flash_we_n_o,
  output logic [ADDR_W-1:0]      flash_addr_o,
  output logic [DATA_W-1:0]      flash_dq_o,
  output logic                   flash_dq_oe_o,
  input  wire logic [DATA_W-1:0] flash_dq_i
);
  typedef enum logic [2:0] {S_IDLE, S_CMD, S_CMD_WAIT, S_POLL, S_POLL_WAIT, S_DONE} state_type;

  logic              rst_meta, rst_sync;
  state_type         state, next_state;
  op_type            op, next_op;
  logic [ADDR_W-1:0] addr, next_addr;
  logic [DATA_W-1:0] data, next_data, last, next_last, rsp_data, next_rsp_data;
  logic [2:0]        step, next_step;
  logic              have_last, next_have_last, rsp_valid, next_rsp_valid;
  logic              rsp_error, next_rsp_error;
  logic [1:0]        confirm, next_confirm;
  logic [TIMER_W-1:0] timer, next_timer, limit;
  logic [ADDR_W-1:0] step_addr;
  logic [DATA_W-1:0] step_data;
  logic [2:0]        last_step;
  flash_bus_if bus ();
  flash_bus_cycle u_cycle (
    .clock_i(clock_i), .rst_sync_i(rst_sync), .clock_en_i(clock_en_i), .bus(bus.engine),
    .flash_ce_n_o(flash_ce_n_o), .flash_oe_n_o(flash_oe_n_o), .flash_we_n_o(flash_we_n_o),
    .flash_addr_o(flash_addr_o), .flash_dq_o(flash_dq_o), .flash_dq_oe_o(flash_dq_oe_o),
    .flash_dq_i(flash_dq_i));
  // reset enters asynchronously, leaves through two flops
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end
    else if (clock_en_i)
    begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // address and data of each command cycle
  always_comb
  begin
    step_addr = UNLOCK_ADDR_A;
    step_data = CODE_UNLOCK_1;
    case (step)
      3'h1, 3'h4:
      begin
        step_addr = UNLOCK_ADDR_B;
        step_data = CODE_UNLOCK_2;
      end
      3'h2:
        step_data = (op == OP_PROGRAM) ? CODE_PROGRAM : CODE_ERASE_SETUP;
      3'h3:
        if (op == OP_PROGRAM)
        begin
          step_addr = addr;
          step_data = data;
        end
      3'h5:
        if (op == OP_CHIP_ERASE)
          step_data = CODE_CHIP_ERASE;
        else
        begin
          step_addr = addr & ((op == OP_SECTOR_ERASE) ? SECTOR_MASK : BLOCK_MASK);
          step_data = (op == OP_SECTOR_ERASE) ? CODE_SECTOR : CODE_BLOCK;
        end
      default:
        step_addr = UNLOCK_ADDR_A;
    endcase
  end
  assign last_step = (op == OP_PROGRAM) ? PROGRAM_STEPS - 3'h1 : ERASE_STEPS - 3'h1;
  assign limit     = (op == OP_PROGRAM) ? TIMER_W'(PROGRAM_LIMIT_CYCLES)
                                        : TIMER_W'(ERASE_LIMIT_CYCLES);
  assign bus.req   = (state == S_CMD) || (state == S_POLL);
  assign bus.write = (state == S_CMD);
  assign bus.addr  = (state == S_CMD) ? step_addr : addr;
  assign bus.wdata = step_data;
  always_comb
  begin
    next_state     = state;
    next_op        = op;
    next_addr      = addr;
    next_data      = data;
    next_step      = step;
    next_last      = last;
    next_have_last = have_last;
    next_confirm   = confirm;
    next_timer     = timer;
    next_rsp_valid = 1'b0;
    next_rsp_data  = rsp_data;
    next_rsp_error = rsp_error;
    // timer runs only in the polling states, after any launching strobe has risen
    if (state == S_POLL || state == S_POLL_WAIT)
      next_timer = timer + 24'h00_0001;
    case (state)
      S_IDLE:
        if (cmd_valid_i)
        begin
          next_op        = cmd_op_i;
          next_addr      = cmd_addr_i;
          next_data      = cmd_data_i;
          next_step      = 3'h0;
          next_have_last = 1'b0;
          next_confirm   = 2'h0;
          next_timer     = '0;
          next_state     = (cmd_op_i == OP_READ) ? S_POLL : S_CMD;
        end
      S_CMD:
        next_state = S_CMD_WAIT;
      S_CMD_WAIT:
        if (bus.done)
        begin
          next_step  = step + 3'h1;
          next_state = (step == last_step) ? S_POLL : S_CMD;
        end
      S_POLL:
        next_state = S_POLL_WAIT;
      S_POLL_WAIT:
        if (bus.done)
        begin
          next_last      = bus.rdata;
          next_have_last = 1'b1;
          next_rsp_data  = bus.rdata;
          next_state     = S_POLL;
          if (op == OP_READ)
          begin
            next_rsp_error = 1'b0;
            next_state     = S_DONE;
          end
          else if (have_last && bus.rdata[TOGGLE_BIT] == last[TOGGLE_BIT])
          begin
            // toggle stopped: two matching rereads confirm the end
            next_confirm = confirm + 2'h1;
            if (confirm + 2'h1 == REREADS)
            begin
              next_state     = S_DONE;
              next_rsp_error = (op == OP_PROGRAM) ? (bus.rdata != data)
                                                  : (bus.rdata != ERASED_WORD);
            end
          end
          else
          begin
            next_confirm = 2'h0;
            if (timer >= limit)
            begin
              next_rsp_error = 1'b1;
              next_state     = S_DONE;
            end
          end
        end
      S_DONE:
      begin
        // flash is back in array read unless the limit ran out; ready for the next command
        next_rsp_valid = 1'b1;
        next_state     = S_IDLE;
      end
      default:
        next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_sync)
  begin
    if (!rst_sync)
    begin
      state     <= S_IDLE;
      op        <= OP_READ;
      addr      <= '0;
      data      <= '0;
      step      <= 3'h0;
      last      <= '0;
      have_last <= 1'b0;
      confirm   <= 2'h0;
      timer     <= '0;
      rsp_valid <= 1'b0;
      rsp_data  <= '0;
      rsp_error <= 1'b0;
    end
    else if (clock_en_i)
    begin
      state     <= next_state;
      op        <= next_op;
      addr      <= next_addr;
      data      <= next_data;
      step      <= next_step;
      last      <= next_last;
      have_last <= next_have_last;
      confirm   <= next_confirm;
      timer     <= next_timer;
      rsp_valid <= next_rsp_valid;
      rsp_data  <= next_rsp_data;
      rsp_error <= next_rsp_error;
    end
  end

  assign cmd_ready_o = (state == S_IDLE);
  assign rsp_valid_o = rsp_valid;
  assign rsp_data_o  = rsp_data;
  assign rsp_error_o = rsp_error;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_sync);
  property p_unlock_first;
    bus.req && bus.write && step == 3'h0 |-> bus.addr == UNLOCK_ADDR_A && bus.wdata == CODE_UNLOCK_1;
  endproperty
  a_unlock_first: assert property (p_unlock_first) else $error("bad first unlock");
  property p_unlock_second;
    bus.req && bus.write && (step == 3'h1 || step == 3'h4)
      |-> bus.addr == UNLOCK_ADDR_B && bus.wdata == CODE_UNLOCK_2;
  endproperty
  a_unlock_second: assert property (p_unlock_second) else $error("bad second unlock");
  property p_program_word;
    bus.req && bus.write && step == 3'h3 && op == OP_PROGRAM |-> bus.addr == addr && bus.wdata == data;
  endproperty
  a_program_word: assert property (p_program_word) else $error("bad program word");
  property p_region_code;
    bus.req && bus.write && step == 3'h5 && op == OP_SECTOR_ERASE
      |-> bus.wdata == CODE_SECTOR && bus.addr == (addr & SECTOR_MASK);
  endproperty
  a_region_code: assert property (p_region_code) else $error("bad sector erase cycle");
  property p_chip_code;
    bus.req && bus.write && step == 3'h5 && op == OP_CHIP_ERASE
      |-> bus.wdata == CODE_CHIP_ERASE && bus.addr == UNLOCK_ADDR_A;
  endproperty
  a_chip_code: assert property (p_chip_code) else $error("bad chip erase cycle");
  property p_program_steps;
    op == OP_PROGRAM && state != S_IDLE |-> step <= PROGRAM_STEPS;
  endproperty
  a_program_steps: assert property (p_program_steps) else $error("program too long");
  property p_confirmed_end;
    $rose(rsp_valid) && op != OP_READ && !rsp_error |-> confirm == REREADS;
  endproperty
  a_confirmed_end: assert property (p_confirmed_end) else $error("end not confirmed");
  property p_status_after_launch;
    state == S_POLL && op != OP_READ |-> step == last_step + 3'h1 && flash_we_n_o;
  endproperty
  a_status_after_launch: assert property (p_status_after_launch) else $error("early poll");
  property p_select_parked;
    state == S_IDLE && $past(state) == S_IDLE |-> flash_ce_n_o;
  endproperty
  a_select_parked: assert property (p_select_parked) else $error("select left low");

  c_program_done: cover property ($rose(rsp_valid) && op == OP_PROGRAM && !rsp_error);
  c_sector_done:  cover property ($rose(rsp_valid) && op == OP_SECTOR_ERASE);
  c_read_done:    cover property ($rose(rsp_valid) && op == OP_READ);
  c_timeout:      cover property ($rose(rsp_valid) && rsp_error);

endmodule : flash_host_sequencer

// ==== hdl/flash_seq_pkg.sv ====
// constants and types shared by the flash host sequencer and its bus cycle engine
package flash_seq_pkg;

  localparam int ADDR_W = 19;
  localparam int DATA_W = 16;
  localparam int CNT_W  = 4;
  localparam int TIMER_W = 24;

  // unlock and command words
  localparam logic [ADDR_W-1:0] UNLOCK_ADDR_A    = 19'h0_5555;
  localparam logic [ADDR_W-1:0] UNLOCK_ADDR_B    = 19'h0_2AAA;
  localparam logic [DATA_W-1:0] CODE_UNLOCK_1    = 16'h00AA;
  localparam logic [DATA_W-1:0] CODE_UNLOCK_2    = 16'h0055;
  localparam logic [DATA_W-1:0] CODE_PROGRAM     = 16'h00A0;
  localparam logic [DATA_W-1:0] CODE_ERASE_SETUP = 16'h0080;
  localparam logic [DATA_W-1:0] CODE_CHIP_ERASE  = 16'h0010;
  localparam logic [DATA_W-1:0] CODE_SECTOR      = 16'h0030;
  localparam logic [DATA_W-1:0] CODE_BLOCK       = 16'h0050;
  localparam logic [DATA_W-1:0] ERASED_WORD      = 16'hFFFF;

  // 2 KWord sectors and 32 KWord blocks
  localparam logic [ADDR_W-1:0] SECTOR_MASK = 19'h7_F800;
  localparam logic [ADDR_W-1:0] BLOCK_MASK  = 19'h7_8000;

  localparam int POLL_BIT   = 7;
  localparam int TOGGLE_BIT = 6;

  localparam logic [2:0] PROGRAM_STEPS = 3'h4;
  localparam logic [2:0] ERASE_STEPS   = 3'h6;
  localparam logic [2:0] LAST_UNLOCK   = 3'h2;
  localparam logic [1:0] REREADS       = 2'h2;

  // timing
  localparam int CLK_PERIOD_NS    = 8;
  localparam int T_WE_LOW_NS      = 40;
  localparam int T_READ_NS        = 70;
  localparam int T_PROGRAM_MAX_NS = 20000;
  localparam int SYNC_STAGES      = 3;

  localparam int WE_LOW_CYCLES  = (T_WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_CYCLES    = (T_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROGRAM_LIMIT_CYCLES = T_PROGRAM_MAX_NS / CLK_PERIOD_NS;

  localparam logic [CNT_W-1:0] WE_LOW_LOAD = CNT_W'(WE_LOW_CYCLES - 1);
  localparam logic [CNT_W-1:0] READ_LOAD   = CNT_W'(READ_CYCLES + SYNC_STAGES - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO    = 4'h0;

  typedef enum logic [2:0] {
    OP_READ,
    OP_PROGRAM,
    OP_SECTOR_ERASE,
    OP_BLOCK_ERASE,
    OP_CHIP_ERASE
  } op_type;

endpackage : flash_seq_pkg

// ==== sim/flash_model.sv ====
// behavioural parallel NOR flash answering the host sequencer's pins
`timescale 1ns/1ps
module flash_model
  import flash_seq_pkg::*;
#(
  parameter int PROG_NS  = 10_000,
  parameter int ERASE_NS = 8_000
)
(
  // flash pins
  input  wire logic              ce_n_i,
  input  wire logic              oe_n_i,
  input  wire logic              we_n_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] dq_i,
  // test control: keeps a word program running past the host's limit
  input  wire logic              stall_i,
  output logic [DATA_W-1:0]      dq_o,
  output logic                   dq_en_o,
  output int                     strobes_o
);
  logic [DATA_W-1:0] mem [int];
  logic [ADDR_W-1:0] la      = '0;
  logic [DATA_W-1:0] rd      = '0;
  logic [DATA_W-1:0] pdata   = '0;
  logic              busy    = 1'b0;
  logic              erasing = 1'b0;
  logic              prog    = 1'b0;
  logic              tgl     = 1'b0;
  int                step    = 0;
  int                n_strobe = 0;

  function automatic logic [DATA_W-1:0] word(input logic [ADDR_W-1:0] a);
    return mem.exists(int'(a)) ? mem[int'(a)] : ERASED_WORD;
  endfunction : word

  task automatic clear(input logic [ADDR_W-1:0] m, input logic [ADDR_W-1:0] a);
    foreach (mem[k])
      if ((ADDR_W'(k) & m) == (a & m)) mem[k] = ERASED_WORD;
  endtask : clear

  task automatic launch(input int t, input logic er);
    step = 0;
    erasing = er;
    busy = 1'b1;
    busy <= #(t) 1'b0;
  endtask : launch

  task automatic take(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic ok;
    ok = 1'b0;
    n_strobe++;
    if (busy) return;
    if (step == 3 && prog) begin
      mem[int'(a)] = word(a) & d;
      pdata = d;
      launch(stall_i ? 4 * PROG_NS : PROG_NS, 1'b0);
      return;
    end
    if (step == 5) begin
      if (d[7:0] == 8'h10 && a[14:0] == 15'h5555) mem.delete();
      else if (d[7:0] == 8'h30) clear(SECTOR_MASK, a);
      else if (d[7:0] == 8'h50) clear(BLOCK_MASK, a);
      else begin
        step = 0;
        return;
      end
      launch(ERASE_NS, 1'b1);
      return;
    end
    case (step)
      0, 3: ok = a[14:0] == 15'h5555 && d[7:0] == 8'hAA;
      1, 4: ok = a[14:0] == 15'h2AAA && d[7:0] == 8'h55;
      2: begin
        ok = a[14:0] == 15'h5555 && (d[7:0] == 8'hA0 || d[7:0] == 8'h80);
        prog = d[7:0] == 8'hA0;
      end
      default: ok = 1'b0;
    endcase
    step = ok ? step + 1 : 0;
  endtask : take

  always @(negedge we_n_i) if (!ce_n_i) la = addr_i;
  always @(negedge ce_n_i) if (!we_n_i) la = addr_i;
  always @(posedge we_n_i) if (!ce_n_i) take(la, dq_i);
  always @(posedge ce_n_i) if (!we_n_i) take(la, dq_i);

  always @(negedge oe_n_i or negedge ce_n_i)
  begin
    // address and both strobes move in the same step: look once they have settled
    #1;
    if (!ce_n_i && !oe_n_i) begin
      tgl = ~tgl;
      if (busy) rd = {8'h00, erasing ? 1'b0 : ~pdata[POLL_BIT], tgl, 6'h00};
      else rd = word(addr_i);
    end
  end

  // a floated bus shows the inverse of the last word so stale data never passes
  assign dq_en_o   = !ce_n_i && !oe_n_i;
  assign dq_o      = dq_en_o ? rd : ~rd;
  assign strobes_o = n_strobe;
endmodule : flash_model

// ==== sim/parallel_nor_flash_command_sequencer_tb_top.sv ====
// testbench for the flash host sequencer against the flash model
`timescale 1ns/1ps
module parallel_nor_flash_command_sequencer_tb_top;
  import flash_seq_pkg::*;
  logic              clock_i;
  logic              rst_n_i;
  logic              clock_en_i;
  logic              cmd_valid_i;
  op_type            cmd_op_i;
  logic [ADDR_W-1:0] cmd_addr_i;
  logic [DATA_W-1:0] cmd_data_i;
  logic              cmd_ready_o;
  logic              rsp_valid_o;
  logic [DATA_W-1:0] rsp_data_o;
  logic              rsp_error_o;
  logic              flash_ce_n_o;
  logic              flash_oe_n_o;
  logic              flash_we_n_o;
  logic [ADDR_W-1:0] flash_addr_o;
  logic [DATA_W-1:0] flash_dq_o;
  logic              flash_dq_oe_o;
  logic [DATA_W-1:0] dq_m;
  logic              dq_en;
  wire  [DATA_W-1:0] dq_bus;
  int                strobes;
  logic              stall;
  int                n_fail = 0;
  int                comparisons = 0;

  assign dq_bus = flash_dq_oe_o ? flash_dq_o : dq_m;

  flash_host_sequencer #(.ERASE_LIMIT_CYCLES(2000)) u_dut (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .clock_en_i(clock_en_i),
    .cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i), .cmd_addr_i(cmd_addr_i),
    .cmd_data_i(cmd_data_i), .cmd_ready_o(cmd_ready_o), .rsp_valid_o(rsp_valid_o),
    .rsp_data_o(rsp_data_o), .rsp_error_o(rsp_error_o), .flash_ce_n_o(flash_ce_n_o),
    .flash_oe_n_o(flash_oe_n_o), .flash_we_n_o(flash_we_n_o),
    .flash_addr_o(flash_addr_o), .flash_dq_o(flash_dq_o),
    .flash_dq_oe_o(flash_dq_oe_o), .flash_dq_i(dq_bus));

  flash_model u_flash (
    .ce_n_i(flash_ce_n_o), .oe_n_i(flash_oe_n_o), .we_n_i(flash_we_n_o),
    .addr_i(flash_addr_o), .dq_i(dq_bus), .dq_o(dq_m), .dq_en_o(dq_en),
    .strobes_o(strobes), .stall_i(stall));

  initial
  begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end

  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop

  // one command through the port; checks error flag and count of write strobes
  task automatic run(input op_type op, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d, input logic err, input int writes);
    int s0;
    int n;
    s0 = strobes;
    n = 0;
    cmd_op_i = op;
    cmd_addr_i = a;
    cmd_data_i = d;
    cmd_valid_i = 1'b1;
    while (cmd_ready_o !== 1'b1 && n < 100)
    begin
      @(negedge clock_i);
      n++;
    end
    @(negedge clock_i);
    cmd_valid_i = 1'b0;
    n = 0;
    while (rsp_valid_o !== 1'b1 && n < 20000)
    begin
      @(negedge clock_i);
      n++;
    end
    check(DATA_W'(rsp_valid_o), 16'h0001);
    check(DATA_W'(rsp_error_o), DATA_W'(err));
    check(DATA_W'(strobes - s0), DATA_W'(writes));
  endtask : run

  task automatic rd_check(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    run(OP_READ, a, 16'h0000, 1'b0, 0);
    check(rsp_data_o, exp);
  endtask : rd_check

  task automatic t_program();
    rd_check(19'h0_0123, ERASED_WORD);
    run(OP_PROGRAM, 19'h0_0123, 16'h1234, 1'b0, 4);
    run(OP_PROGRAM, 19'h0_0923, 16'h5A5A, 1'b0, 4);
    run(OP_PROGRAM, 19'h0_9000, 16'h00C3, 1'b0, 4);
    rd_check(19'h0_0123, 16'h1234);
    // bits can only be cleared, so a rewrite without erase must be flagged
    run(OP_PROGRAM, 19'h0_0123, 16'h00FF, 1'b1, 4);
    check(rsp_data_o, 16'h0034);
    $display("test program done");
  endtask : t_program

  task automatic t_erase();
    run(OP_SECTOR_ERASE, 19'h0_0456, 16'h0000, 1'b0, 6);
    rd_check(19'h0_0123, ERASED_WORD);
    rd_check(19'h0_0923, 16'h5A5A);
    run(OP_BLOCK_ERASE, 19'h0_9FFF, 16'h0000, 1'b0, 6);
    rd_check(19'h0_9000, ERASED_WORD);
    rd_check(19'h0_0923, 16'h5A5A);
    run(OP_CHIP_ERASE, 19'h0_0923, 16'h0000, 1'b0, 6);
    rd_check(19'h0_0923, ERASED_WORD);
    $display("test erase done");
  endtask : t_erase

  // a word program that outlasts the host's limit must be cut off by that limit
  task automatic t_timeout();
    stall = 1'b1;
    run(OP_PROGRAM, 19'h0_0001, 16'h0F0F, 1'b1, 4);
    stall = 1'b0;
    $display("test timeout done");
  endtask : t_timeout

  // host and flash must never drive the data lines together
  always @(negedge clock_i)
    if (flash_dq_oe_o === 1'b1 && dq_en === 1'b1) check(16'h0001, 16'h0000);

  initial
  begin
    #400_000;
    n_fail++;
    $display("watchdog expired");
    report_and_stop();
  end

  initial
  begin
    rst_n_i = 1'b0;
    stall = 1'b0;
    clock_en_i = 1'b1;
    cmd_valid_i = 1'b0;
    cmd_op_i = OP_READ;
    cmd_addr_i = '0;
    cmd_data_i = '0;
    repeat (12) @(negedge clock_i);
    check({9'h000, flash_ce_n_o, flash_we_n_o, flash_oe_n_o, flash_dq_oe_o, rsp_valid_o,
           rsp_error_o, cmd_ready_o}, 16'h0071);
    rst_n_i = 1'b1;
    repeat (3) @(negedge clock_i);
    t_program();
    t_erase();
    t_timeout();
    report_and_stop();
  end
endmodule : parallel_nor_flash_command_sequencer_tb_top
